// file: rtl/kiu_pkg.sv
// Package with register map, field positions and bus types of the keypad unit.
package kiu_pkg;
   localparam logic [7:0] KIU_OFS_STATUS_CONTROL = 8'h1B;
   localparam logic [7:0] KIU_OFS_PIN_ENABLES = 8'h21;
   localparam int KIU_NUM_PINS = 5;
   localparam int KIU_BIT_PENDING = 3;
   localparam int KIU_BIT_ACK = 2;
   localparam int KIU_BIT_MASK = 1;
   localparam int KIU_BIT_SENSE = 0;
   localparam logic KIU_RST_MASK = 1'b0;
   localparam logic KIU_RST_SENSE = 1'b0;
   localparam logic KIU_RST_REQ = 1'b0;
   localparam logic [4:0] KIU_RST_PIN_EN = 5'h00;
   localparam logic [7:0] KIU_RST_RDATA = 8'h00;
   localparam logic [15:0] KIU_VECTOR_HI_ADDR = 16'hFFDE;
   localparam logic [15:0] KIU_VECTOR_LO_ADDR = 16'hFFDF;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } kiu_bus_req_t;

   typedef struct packed {
      logic active;
      logic clear_enable;
   } kiu_break_t;
endpackage

// file: rtl/kiu_keypad_interrupt_unit.sv
// Keypad interrupt unit: five pin request latch, mask, acknowledge, wake.
`timescale 1ns/1ps
`default_nettype none
module kiu_keypad_interrupt_unit
   import kiu_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire kiu_bus_req_t i_bus,
   output logic [7:0] o_rd_data,
   input wire logic [KIU_NUM_PINS-1:0] i_kbd_pin,
   input wire logic i_vec_fetch,
   input wire logic i_low_power,
   input wire kiu_break_t i_break,
   output logic [KIU_NUM_PINS-1:0] o_pullup_en,
   output logic [KIU_NUM_PINS-1:0] o_force_input,
   output logic o_irq,
   output logic o_wake
);
   logic rst_s1_ff;
   logic rst_s2_ff;
   logic rst_b;
   logic [KIU_NUM_PINS-1:0] pin_s1_ff;
   logic [KIU_NUM_PINS-1:0] pin_s2_ff;
   logic [KIU_NUM_PINS-1:0] pin_en_ff;
   logic any_low;
   logic prev_low_ff;
   logic fall;
   logic mask_ff;
   logic sense_ff;
   logic req_ff;
   logic nxt_req;
   logic acked_ff;
   logic nxt_acked;
   logic ack_wr;
   logic ack;
   logic wr_sc;
   logic wr_en;
   logic [7:0] nxt_rd_data;
   logic irq_ff;
   logic wake_ff;

   // Reset is asserted at once and released through two flops.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_s1_ff <= 1'b0;
         rst_s2_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_s2_ff <= rst_s1_ff;
      end
   end
   assign rst_b = rst_s2_ff;

   // Pins are asynchronous; only the second stage feeds the detectors.
   // Each pin has its own pair of flops, so one pin never depends on
   // the stages of another.
   // The flops reset high, the idle level of a released key, so that no
   // false edge is seen as reset ends.
   for (genvar g = 0; g < KIU_NUM_PINS; g++) begin : g_pin_sync
      always_ff @(posedge i_ref_clk or negedge rst_b) begin
         if (!rst_b) begin
            pin_s1_ff[g] <= 1'b1;
            pin_s2_ff[g] <= 1'b1;
         end else begin
            pin_s1_ff[g] <= i_kbd_pin[g];
            pin_s2_ff[g] <= pin_s1_ff[g];
         end
      end
   end

   assign wr_sc = i_bus.wr && (i_bus.addr == KIU_OFS_STATUS_CONTROL);
   assign wr_en = i_bus.wr && (i_bus.addr == KIU_OFS_PIN_ENABLES);

   // Pin enable register.
   always_ff @(posedge i_ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_en_ff <= KIU_RST_PIN_EN;
      end else if (wr_en) begin
         pin_en_ff <= i_bus.wdata[KIU_NUM_PINS-1:0];
      end
   end
   assign o_pullup_en = pin_en_ff;
   assign o_force_input = pin_en_ff;

   // Mask and sensitivity bits.
   always_ff @(posedge i_ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_ff <= KIU_RST_MASK;
         sense_ff <= KIU_RST_SENSE;
      end else if (wr_sc) begin
         mask_ff <= i_bus.wdata[KIU_BIT_MASK];
         sense_ff <= i_bus.wdata[KIU_BIT_SENSE];
      end
   end

   // A disabled pin never counts as low, so disabling a stuck pin
   // lets the other pins raise edges again.
   assign any_low = |(~pin_s2_ff & pin_en_ff);
   always_ff @(posedge i_ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_low_ff <= 1'b0;
      end else begin
         prev_low_ff <= any_low;
      end
   end
   assign fall = any_low && !prev_low_ff;

   // During break the acknowledge write is dropped unless allowed.
   assign ack_wr = wr_sc && i_bus.wdata[KIU_BIT_ACK] &&
                   (!i_break.active || i_break.clear_enable);
   assign ack = i_vec_fetch || ack_wr;

   // A new edge wins over a clear in the same cycle.
   always_comb begin
      nxt_req = req_ff;
      nxt_acked = acked_ff;
      if (fall) begin
         nxt_req = 1'b1;
         nxt_acked = 1'b0;
      end else if (!sense_ff) begin
         if (ack) begin
            nxt_req = 1'b0;
         end
         nxt_acked = 1'b0;
      end else if (req_ff) begin
         if ((ack || acked_ff) && !any_low) begin
            nxt_req = 1'b0;
            nxt_acked = 1'b0;
         end else if (ack) begin
            nxt_acked = 1'b1;
         end
      end else begin
         // A pin that is already low when level mode is chosen still
         // counts as a request.
         nxt_req = any_low;
         nxt_acked = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         req_ff <= KIU_RST_REQ;
      end else begin
         req_ff <= nxt_req;
      end
   end

   // Remembers a level-mode acknowledge until all enabled pins return high.
   always_ff @(posedge i_ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         acked_ff <= 1'b0;
      end else begin
         acked_ff <= nxt_acked;
      end
   end

   // Interrupt and wake outputs; the vector itself lives in the CPU.
   always_ff @(posedge i_ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_ff <= 1'b0;
         wake_ff <= 1'b0;
      end else begin
         irq_ff <= nxt_req && !mask_ff;
         wake_ff <= nxt_req && !mask_ff && i_low_power;
      end
   end
   assign o_irq = irq_ff;
   assign o_wake = wake_ff;

   // Read port; acknowledge and upper bits always read zero.
   always_comb begin
      nxt_rd_data = KIU_RST_RDATA;
      if (i_bus.rd) begin
         case (i_bus.addr)
            KIU_OFS_STATUS_CONTROL: begin
               nxt_rd_data[KIU_BIT_PENDING] = req_ff;
               nxt_rd_data[KIU_BIT_MASK] = mask_ff;
               nxt_rd_data[KIU_BIT_SENSE] = sense_ff;
            end
            KIU_OFS_PIN_ENABLES: begin
               nxt_rd_data[KIU_NUM_PINS-1:0] = pin_en_ff;
            end
            default: begin
               nxt_rd_data = KIU_RST_RDATA;
            end
         endcase
      end
   end
   always_ff @(posedge i_ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         o_rd_data <= KIU_RST_RDATA;
      end else begin
         o_rd_data <= nxt_rd_data;
      end
   end

   // Edge and level detection, and the pin synchroniser.
   a_edge_sets_req: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      fall |=> req_ff
   ) else $error("Edge did not latch request.");

   a_edge_blocked: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      !sense_ff && !req_ff && prev_low_ff && !i_bus.wr && !i_vec_fetch
      && $stable(pin_en_ff) |=> !req_ff
   ) else $error("Request latched while a pin was low.");

   a_level_holds: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      sense_ff && req_ff && any_low && !wr_sc |=> req_ff
   ) else $error("Level request dropped while pin low.");

   a_level_clear: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      sense_ff && req_ff && acked_ff && !any_low && !fall |=> !req_ff
   ) else $error("Acknowledged level request not cleared.");

   a_edge_wins_ack: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      ack && fall |=> req_ff
   ) else $error("Edge after acknowledge was lost.");

   a_pin_sync: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      ##1 pin_s2_ff == $past(pin_s1_ff)
   ) else $error("Pin synchroniser stage skipped.");

   // Acknowledge paths.
   a_edge_ack_clr: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      !sense_ff && ack && !fall |=> !req_ff
   ) else $error("Edge request not cleared by acknowledge.");

   a_vec_ack: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      !sense_ff && i_vec_fetch && !fall |=> !req_ff
   ) else $error("Vector fetch did not clear request.");

   a_break_protect: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      i_break.active && !i_break.clear_enable && !i_vec_fetch && req_ff
      && !acked_ff |=> req_ff
   ) else $error("Flag cleared in protected break.");

   // Interrupt and wake outputs.
   a_irq_masked: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      mask_ff |=> !o_irq
   ) else $error("Masked request reached the interrupt.");

   a_irq_pending: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      !mask_ff && nxt_req |=> o_irq
   ) else $error("Unmasked request gave no interrupt.");

   a_wake_out: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      i_low_power && nxt_req && !mask_ff |=> o_wake
   ) else $error("Unmasked request did not wake.");

   a_wake_idle: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      !i_low_power |=> !o_wake
   ) else $error("Wake raised outside low power.");

   // Register writes and pin controls.
   a_en_write: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      wr_en |=> pin_en_ff == $past(i_bus.wdata[KIU_NUM_PINS-1:0])
   ) else $error("Pin enable write lost.");

   a_pullup_follows: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      o_pullup_en == pin_en_ff
   ) else $error("Pull-up does not follow pin enable.");

   a_force_input: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      o_force_input == pin_en_ff
   ) else $error("Input force does not follow pin enable.");

   a_sense_write: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      wr_sc |=> sense_ff == $past(i_bus.wdata[KIU_BIT_SENSE])
   ) else $error("Sensitivity write lost.");

   a_mask_write: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      wr_sc |=> mask_ff == $past(i_bus.wdata[KIU_BIT_MASK])
   ) else $error("Mask write lost.");

   // Read port.
   a_status_read: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      i_bus.rd && i_bus.addr == KIU_OFS_STATUS_CONTROL
      |=> o_rd_data[7:4] == 4'h0 && !o_rd_data[KIU_BIT_ACK]
      && o_rd_data[KIU_BIT_PENDING] == $past(req_ff)
   ) else $error("Status read data wrong.");

   a_en_read: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      i_bus.rd && i_bus.addr == KIU_OFS_PIN_ENABLES
      |=> o_rd_data[7:5] == 3'h0
      && o_rd_data[KIU_NUM_PINS-1:0] == $past(pin_en_ff)
   ) else $error("Pin enable read data wrong.");

   a_rd_idle: assert property (
      @(posedge i_ref_clk) disable iff (!rst_b)
      !i_bus.rd |=> o_rd_data == KIU_RST_RDATA
   ) else $error("Read data stands without a read.");

   // Reset values; these watch the reset itself, so none is disabled.
   a_rst_req: assert property (
      @(posedge i_ref_clk)
      !rst_b |-> !req_ff && !sense_ff && !mask_ff
   ) else $error("Reset left request or control bits set.");

   a_rst_enables: assert property (
      @(posedge i_ref_clk)
      !rst_b |-> pin_en_ff == KIU_RST_PIN_EN
   ) else $error("Reset left a pin enabled.");

   a_rst_outputs: assert property (
      @(posedge i_ref_clk)
      !rst_b |-> !o_irq && !o_wake
   ) else $error("Interrupt or wake high during reset.");
endmodule
`default_nettype wire

// file: testbench/kiu_keypad_model.sv
// Keypad switch model: pressed keys pull low, released keys follow pull-ups.
`timescale 1ns/1ps
`default_nettype none
module kiu_keypad_model (
   input wire logic i_ref_clk,
   input wire logic [4:0] i_press,
   input wire logic [4:0] i_pullup_en,
   output logic [4:0] o_pin
);
   logic tog_ff = 1'b0;
   always_ff @(posedge i_ref_clk) begin
      tog_ff <= ~tog_ff;
   end
   // A released key without pull-up floats, so it toggles to expose misuse.
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         o_pin[i] = i_press[i] ? 1'b0 : (i_pullup_en[i] ? 1'b1 : tog_ff);
      end
   end
endmodule
`default_nettype wire

// file: testbench/kiu_keypad_interrupt_unit_test.sv
// Self-checking bench of the keypad interrupt unit with a keypad model.
`timescale 1ns/1ps
`default_nettype none
module kiu_keypad_interrupt_unit_test;
   import kiu_pkg::*;
   localparam logic [7:0] SC = KIU_OFS_STATUS_CONTROL;
   localparam logic [7:0] EN = KIU_OFS_PIN_ENABLES;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   kiu_bus_req_t bus = '0;
   logic [7:0] rdat;
   logic [4:0] press = 5'h00;
   logic [4:0] pin, pull, frc;
   logic vec = 1'b0;
   logic lowp = 1'b0;
   kiu_break_t brk = '0;
   logic irq, wake;
   logic [31:0] seed = 32'hA3A160BF;
   int error_cnt = 0;
   int n_checks = 0;
   kiu_keypad_interrupt_unit uut (.i_ref_clk(clk), .i_rst_b(rst_b),
      .i_bus(bus), .o_rd_data(rdat), .i_kbd_pin(pin), .i_vec_fetch(vec),
      .i_low_power(lowp), .i_break(brk), .o_pullup_en(pull),
      .o_force_input(frc), .o_irq(irq), .o_wake(wake));
   kiu_keypad_model keys (.i_ref_clk(clk), .i_press(press),
      .i_pullup_en(pull), .o_pin(pin));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string w, input logic [7:0] s, e);
      n_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk) bus <= '0;
      #1;
   endtask
   task automatic rc(input logic [7:0] a, e);
      @(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk) bus <= '0;
      #1;
      chk("read data", rdat, e);
   endtask
   task automatic key(input logic [4:0] p);
      @(posedge clk) press <= p;
      cyc(5);
   endtask
   task automatic vf();
      @(posedge clk) vec <= 1'b1;
      @(posedge clk) vec <= 1'b0;
      cyc(2);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      summarize();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      cyc(4);
      rc(SC, 8'h00);
      rc(EN, 8'h00);
      wr(8'h40, 8'hFF);
      rc(8'h40, 8'h00);
      rc(EN, 8'h00);
      $display("reset and map test done");
      wr(SC, 8'h02);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         wr(EN, seed[7:0]);
         rc(EN, {3'h0, seed[4:0]});
         chk("pull-ups", pull, seed[4:0]);
         chk("force input", frc, seed[4:0]);
      end
      wr(EN, 8'h03);
      cyc(4);
      wr(SC, 8'h06);
      wr(SC, 8'h00);
      key(5'h1C);
      rc(SC, 8'h00);
      key(5'h00);
      $display("enable test done");
      key(5'h01);
      chk("irq", irq, 8'h01);
      rc(SC, 8'h08);
      key(5'h03);
      vf();
      chk("irq", irq, 8'h00);
      rc(SC, 8'h00);
      key(5'h02);
      key(5'h03);
      rc(SC, 8'h00);
      key(5'h00);
      key(5'h01);
      wr(SC, 8'h04);
      rc(SC, 8'h00);
      key(5'h00);
      key(5'h02);
      chk("irq", irq, 8'h01);
      $display("edge test done");
      wr(SC, 8'h02);
      cyc(2);
      chk("irq", irq, 8'h00);
      rc(SC, 8'h0A);
      @(posedge clk) lowp <= 1'b1;
      cyc(2);
      chk("wake", wake, 8'h00);
      wr(SC, 8'h00);
      cyc(2);
      chk("wake", wake, 8'h01);
      chk("irq", irq, 8'h01);
      @(posedge clk) lowp <= 1'b0;
      wr(SC, 8'h04);
      key(5'h00);
      $display("mask test done");
      wr(SC, 8'h01);
      key(5'h01);
      vf();
      rc(SC, 8'h09);
      key(5'h00);
      rc(SC, 8'h01);
      key(5'h01);
      key(5'h00);
      rc(SC, 8'h09);
      wr(SC, 8'h05);
      rc(SC, 8'h01);
      $display("level test done");
      wr(SC, 8'h00);
      key(5'h01);
      @(posedge clk) brk <= '{active: 1'b1, clear_enable: 1'b0};
      wr(SC, 8'h04);
      rc(SC, 8'h08);
      @(posedge clk) brk <= '{active: 1'b1, clear_enable: 1'b1};
      wr(SC, 8'h04);
      @(posedge clk) brk <= '0;
      rc(SC, 8'h00);
      $display("break test done");
      wr(SC, 8'h03);
      rc(SC, 8'h0B);
      chk("irq", irq, 8'h00);
      @(posedge clk) rst_b <= 1'b0;
      cyc(2);
      rst_b <= 1'b1;
      cyc(4);
      rc(SC, 8'h00);
      rc(EN, 8'h00);
      chk("irq", irq, 8'h00);
      chk("wake", wake, 8'h00);
      $display("second reset test done");
      summarize();
   end
endmodule
`default_nettype wire
